// ---- src/timer_pkg.sv ----
package timer_pkg;
    // register word indices (printed offsets are not multiples of four: byte address is index times four)
    localparam logic [7:0] IDX_TIMER_COUNT = 8'h01;
    localparam logic [7:0] IDX_INTERRUPT_CONTROL = 8'h0B;
    localparam logic [7:0] IDX_INTERRUPT_CONTROL_HI = 8'h8B;
    localparam logic [7:0] IDX_TIMER_OPTION = 8'h81;
    localparam logic [7:0] IDX_PIN_DIRECTION_A = 8'h85;
    localparam logic [7:0] IDX_IRQ_STATUS = 8'hC0;
    localparam logic [7:0] IDX_IRQ_MASK = 8'hC1;
    localparam logic [7:0] IDX_WATCHDOG_CTRL = 8'hC2;
    localparam int ADDR_W = 10;
    // option field positions
    localparam int OPT_PULLUP_DISABLE = 7;
    localparam int OPT_EXT_IRQ_EDGE = 6;
    localparam int OPT_CLOCK_SOURCE_SEL = 5;
    localparam int OPT_SOURCE_EDGE_SEL = 4;
    localparam int OPT_PRESCALER_ASSIGN = 3;
    // interrupt control field positions
    localparam int ICR_GLOBAL_IRQ_ENABLE = 7;
    localparam int ICR_OVERFLOW_IRQ_ENABLE = 5;
    localparam int ICR_OVERFLOW_FLAG = 2;
    // watchdog control bits (writing one to the clear bit acts; the hard reset bit is never decoded)
    localparam int WDC_CLEAR = 0;
    localparam int WDC_HARD_RESET = 1;
    // reset values
    localparam logic [7:0] OPTION_RESET = 8'hFF;
    localparam logic [4:0] DIRECTION_A_RESET = 5'h1F;
    localparam logic [7:0] ICR_RESET = 8'h00;
    localparam logic [1:0] IRQ_RESET = 2'h0;
    // cycles during which timer increments are held off after a timer write
    localparam logic [1:0] WRITE_INHIBIT_CYCLES = 2'h2;
    // interrupt status bit positions
    localparam int IRQ_OVERFLOW = 0;
    localparam int IRQ_WDT_ROLL = 1;

    typedef struct packed {
        logic [7:0] timer_count;
        logic [7:0] icr;
        logic [7:0] option;
        logic [4:0] direction_a;
    } sw_regs_t;
endpackage

// ---- src/timer_prescaler_switch.sv ----
`timescale 1ns/1ps
`default_nettype none
module timer_prescaler_switch (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic por_i,
    input wire logic ext_count_input_i,
    input wire logic watchdog_tick_i,
    input wire logic watchdog_clear_instr_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [timer_pkg::ADDR_W-1:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic watchdog_tick_o,
    output logic [4:0] pin_direction_a_o,
    output logic irq_o
);
    timer_pkg::sw_regs_t regs;
    logic [7:0] prescale_count;
    logic [1:0] inhibit_count;
    logic [1:0] irq_status;
    logic [1:0] irq_mask;
    logic ext_prev;
    logic prescale_pulse;
    logic timer_inc;
    logic wdt_out;
    logic access;
    logic wr;
    logic [7:0] idx;
    logic [7:0] next_read;
    logic timer_wr;
    logic option_wr;
    logic icr_wr;
    logic wdc_wr;
    logic wdt_clear;
    logic raw_tick;
    logic pin_edge;
    logic timer_src;
    logic dir_wr;
    logic status_wr;
    logic mask_wr;
    logic assign_wdt;
    logic overflow;

    // byte address must be word aligned; index is word number
    function automatic logic hit(input logic [timer_pkg::ADDR_W-1:0] a, input logic [7:0] i);
        hit = (a[1:0] == 2'h0) && (a[timer_pkg::ADDR_W-1:2] == i);
    endfunction

    // prescaler output for ratio field n: one single-count pulse every 2^(n+1) counts
    function automatic logic ratio_tap(input logic [7:0] cnt, input logic [2:0] n);
        logic [7:0] mask;
        mask = 8'hFF >> (3'h7 - n);
        ratio_tap = (cnt & mask) == mask;
    endfunction

    assign access = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wr = access && wb_we_i && wb_sel_i[0];
    assign idx = wb_adr_i[9:2];
    assign assign_wdt = regs.option[timer_pkg::OPT_PRESCALER_ASSIGN];
    assign timer_wr = wr && hit(wb_adr_i, timer_pkg::IDX_TIMER_COUNT);
    assign option_wr = wr && hit(wb_adr_i, timer_pkg::IDX_TIMER_OPTION);
    assign icr_wr = wr && (hit(wb_adr_i, timer_pkg::IDX_INTERRUPT_CONTROL)
        || hit(wb_adr_i, timer_pkg::IDX_INTERRUPT_CONTROL_HI));
    assign wdc_wr = wr && hit(wb_adr_i, timer_pkg::IDX_WATCHDOG_CTRL)
        && wb_dat_i[timer_pkg::WDC_CLEAR];
    assign wdt_clear = watchdog_clear_instr_i || wdc_wr;

    // strobes for the registers that own the rest of the map
    assign dir_wr = wr && hit(wb_adr_i, timer_pkg::IDX_PIN_DIRECTION_A);
    assign status_wr = wr && hit(wb_adr_i, timer_pkg::IDX_IRQ_STATUS);
    assign mask_wr = wr && hit(wb_adr_i, timer_pkg::IDX_IRQ_MASK);

    // counter pin edge, polarity from the edge select bit
    always_comb
    begin
        if (regs.option[timer_pkg::OPT_SOURCE_EDGE_SEL])
        begin
            pin_edge = ext_prev && !ext_count_input_i; // falling
        end
        else
        begin
            pin_edge = !ext_prev && ext_count_input_i; // rising
        end
    end

    // timer source: every clock in timer mode, pin edges in counter mode
    always_comb
    begin
        if (regs.option[timer_pkg::OPT_CLOCK_SOURCE_SEL])
        begin
            timer_src = pin_edge;
        end
        else
        begin
            timer_src = 1'b1;
        end
    end

    // prescaler input follows its owner; the timer keeps its own source
    // while the watchdog holds the prescaler, so a switch never stalls it
    always_comb
    begin
        if (assign_wdt)
        begin
            raw_tick = watchdog_tick_i;
        end
        else
        begin
            raw_tick = timer_src;
        end
    end

    // previous pin sample for the edge detector; pin is already synchronous
    always_ff @(posedge clk_i)
    begin
        ext_prev <= ext_count_input_i;
    end

    // the prescaler always counts for its owner; ownership can flip mid-run
    assign prescale_pulse = raw_tick && ratio_tap(prescale_count, regs.option[2:0]);
    assign timer_inc = assign_wdt ? timer_src : prescale_pulse;
    assign wdt_out = assign_wdt ? prescale_pulse : 1'b0;

    // shared 8-bit prescaler; cleared by its owner's clear event
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            prescale_count <= 8'h00;
        end
        else if (!assign_wdt && timer_wr)
        begin
            prescale_count <= 8'h00;
        end
        else if (assign_wdt && wdt_clear)
        begin
            prescale_count <= 8'h00;
        end
        else if (raw_tick)
        begin
            prescale_count <= prescale_count + 8'h01;
        end
    end

    // watchdog side sees either the raw tick or the divided tick
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            watchdog_tick_o <= 1'b0;
        end
        else
        begin
            watchdog_tick_o <= assign_wdt ? wdt_out : watchdog_tick_i;
        end
    end

    // hold-off after a timer write; software compensates by writing an adjusted value
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            inhibit_count <= 2'h0;
        end
        else if (timer_wr)
        begin
            inhibit_count <= timer_pkg::WRITE_INHIBIT_CYCLES;
        end
        else if (inhibit_count != 2'h0)
        begin
            inhibit_count <= inhibit_count - 2'h1;
        end
    end

    // a write in the same cycle replaces the count, so it never overflows then
    assign overflow = timer_inc && (inhibit_count == 2'h0) && !timer_wr
        && (regs.timer_count == 8'hFF);

    // timer count: power-on clears it, other resets leave it alone
    always_ff @(posedge clk_i)
    begin
        if (por_i)
        begin
            regs.timer_count <= 8'h00;
        end
        else if (timer_wr)
        begin
            regs.timer_count <= wb_dat_i[7:0];
        end
        else if (timer_inc && inhibit_count == 2'h0)
        begin
            regs.timer_count <= regs.timer_count + 8'h01;
        end
    end

    // option loads ones on every reset; writes take effect at once
    always_ff @(posedge clk_i)
    begin
        if (rst_i || por_i)
        begin
            regs.option <= timer_pkg::OPTION_RESET;
        end
        else if (option_wr)
        begin
            regs.option <= wb_dat_i[7:0];
        end
    end

    // port direction: only five bits are stored
    always_ff @(posedge clk_i)
    begin
        if (rst_i || por_i)
        begin
            regs.direction_a <= timer_pkg::DIRECTION_A_RESET;
        end
        else if (dir_wr)
        begin
            regs.direction_a <= wb_dat_i[4:0];
        end
    end
    assign pin_direction_a_o = regs.direction_a;

    // interrupt control; overflow set wins over a same-cycle software write
    always_ff @(posedge clk_i)
    begin
        if (rst_i || por_i)
        begin
            regs.icr <= timer_pkg::ICR_RESET;
        end
        else
        begin
            if (icr_wr)
            begin
                regs.icr <= wb_dat_i[7:0];
            end
            if (overflow)
            begin
                regs.icr[timer_pkg::ICR_OVERFLOW_FLAG] <= 1'b1;
            end
        end
    end

    // sticky status, write one to clear; a new event beats the clear
    always_ff @(posedge clk_i)
    begin
        if (rst_i || por_i)
        begin
            irq_status <= timer_pkg::IRQ_RESET;
        end
        else
        begin
            if (status_wr)
            begin
                irq_status <= irq_status & ~wb_dat_i[1:0];
            end
            if (overflow)
            begin
                irq_status[timer_pkg::IRQ_OVERFLOW] <= 1'b1;
            end
            if (wdt_out)
            begin
                irq_status[timer_pkg::IRQ_WDT_ROLL] <= 1'b1;
            end
        end
    end

    // mask uses the status layout; all sources masked after reset
    always_ff @(posedge clk_i)
    begin
        if (rst_i || por_i)
        begin
            irq_mask <= timer_pkg::IRQ_RESET;
        end
        else if (mask_wr)
        begin
            irq_mask <= wb_dat_i[1:0];
        end
    end

    // level output straight from registers, no glitch-prone event terms
    assign irq_o = |(irq_status & irq_mask);

    // read mux; unmapped and unimplemented bits read zero
    always_comb
    begin
        next_read = 8'h00;
        if (wb_adr_i[1:0] == 2'h0)
        begin
            case (idx)
                timer_pkg::IDX_TIMER_COUNT: next_read = regs.timer_count;
                timer_pkg::IDX_INTERRUPT_CONTROL: next_read = regs.icr;
                timer_pkg::IDX_INTERRUPT_CONTROL_HI: next_read = regs.icr;
                timer_pkg::IDX_TIMER_OPTION: next_read = regs.option;
                timer_pkg::IDX_PIN_DIRECTION_A: next_read = {3'h0, regs.direction_a};
                timer_pkg::IDX_IRQ_STATUS: next_read = {6'h00, irq_status};
                timer_pkg::IDX_IRQ_MASK: next_read = {6'h00, irq_mask};
                default: next_read = 8'h00;
            endcase
        end
    end

    // single-cycle registered ack, data held with it
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end
        else
        begin
            wb_ack_o <= access;
            if (access && !wb_we_i)
            begin
                wb_dat_o <= {24'h000000, next_read};
            end
        end
    end
endmodule
`default_nettype wire

// ---- tb/timer_prescaler_switch_sva.sv ----
`timescale 1ns/1ps
`default_nettype none
module timer_prescaler_switch_sva (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic por_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [timer_pkg::ADDR_W-1:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic watchdog_tick_o,
    input wire logic [4:0] pin_direction_a_o,
    input wire logic irq_o
);
    logic take;
    logic dir_wr;
    // a request counts once: the master holds it through the ack edge
    assign take = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign dir_wr = take && wb_we_i && wb_sel_i[0] && wb_adr_i == 10'h214;
    // power-on only comes beside the plain reset, so either one silences the checks
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i || por_i);
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
    a_ack_answer: assert property (take |=> wb_ack_o)
        else $error("request not answered on the next edge");
    a_ack_cause: assert property (wb_ack_o |-> $past(take))
        else $error("ack without a request");
    a_upper_zero: assert property (wb_dat_o[31:8] == 24'h0)
        else $error("read data upper bits not zero");
    a_dir_reset: assert property ($fell(rst_i) |-> pin_direction_a_o == 5'h1F)
        else $error("direction not all inputs after reset");
    a_dir_write: assert property (dir_wr |=> pin_direction_a_o == wb_dat_i[4:0])
        else $error("direction write lost");
    a_dir_hold: assert property (!dir_wr |=> $stable(pin_direction_a_o))
        else $error("direction changed without a write");
    a_dir_read: assert property (take && !wb_we_i && wb_adr_i == 10'h214
        |=> wb_dat_o == {27'h0, pin_direction_a_o})
        else $error("direction read mismatch");
    a_odd_read: assert property (take && !wb_we_i && wb_adr_i[1:0] != 2'h0
        |=> wb_dat_o == 32'h0)
        else $error("unaligned read not zero");
    c_write: cover property (take && wb_we_i);
    c_irq: cover property ($rose(irq_o));
    c_tick: cover property (watchdog_tick_o);
endmodule
bind timer_prescaler_switch timer_prescaler_switch_sva u_timer_prescaler_switch_sva (.clk_i,
    .rst_i, .por_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_i, .wb_sel_i,
    .wb_dat_o, .wb_ack_o, .watchdog_tick_o, .pin_direction_a_o, .irq_o);
`default_nettype wire

// ---- tb/timer_prescaler_switch_test.sv ----
`timescale 1ns/1ps
`default_nettype none
module timer_prescaler_switch_test;
    logic clk_i = 1'b0, rst_i = 1'b1, por_i = 1'b1, watchdog_tick_i = 1'b0;
    logic watchdog_clear_instr_i = 1'b0;
    logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, wb_ack_o, irq_o, watchdog_tick_o;
    logic [timer_pkg::ADDR_W-1:0] wb_adr_i = 10'h000;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o, q, r;
    logic [4:0] pin_direction_a_o;
    int error_cnt = 0, n_compared = 0;
    // counter pin stays idle: counter mode is only used to hold the count still
    timer_prescaler_switch u_timer_prescaler_switch (.clk_i, .rst_i, .por_i, .watchdog_tick_i,
        .ext_count_input_i(1'b0), .watchdog_clear_instr_i, .wb_cyc_i, .wb_stb_i,
        .wb_we_i, .wb_adr_i, .wb_dat_i, .wb_sel_i(4'h1), .wb_dat_o, .wb_ack_o,
        .watchdog_tick_o, .pin_direction_a_o, .irq_o);
    // 50 MHz
    initial forever #10 clk_i = ~clk_i;
    // one classic cycle; data is taken at the ack edge, release follows it
    task automatic acc(input logic w, input logic [9:0] a, input logic [31:0] d);
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= w;
        wb_adr_i <= a;
        wb_dat_i <= d;
        // look between edges so the ack is settled, then release after its edge
        do
            @(negedge clk_i);
        while (wb_ack_o !== 1'b1);
        q = wb_dat_o;
        @(posedge clk_i);
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // one-cycle pulses on the watchdog tick and clear-instruction pins
    task automatic tick();
        watchdog_tick_i <= 1'b1;
        @(posedge clk_i);
        watchdog_tick_i <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic wclr();
        watchdog_clear_instr_i <= 1'b1;
        @(posedge clk_i);
        watchdog_clear_instr_i <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic rd(input logic [9:0] a, input logic [31:0] exp);
        acc(1'b0, a, 32'h0);
        chk(q, exp);
    endtask
    task automatic conclude();
        $display("compared %0d, errors %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // the full run is about 6000 cycles
    initial
    begin
        #400000;
        error_cnt++;
        conclude();
    end
    initial
    begin
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        por_i <= 1'b0;
        rd(10'h204, 32'hFF);
        rd(10'h004, 32'h00);
        rd(10'h02C, 32'h00);
        acc(1'b1, 10'h214, 32'hFFFFFFEA);
        rd(10'h214, 32'h0A);
        rd(10'h216, 32'h00);
        // counter mode with an idle pin freezes the count across a plain reset
        acc(1'b1, 10'h004, 32'h5A);
        acc(1'b1, 10'h204, 32'h3A);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(10'h004, 32'h5A);
        rd(10'h204, 32'hFF);
        rd(10'h214, 32'h1F);
        // read right after the write lands inside the two held-off cycles
        acc(1'b1, 10'h204, 32'h08);
        acc(1'b1, 10'h004, 32'hFD);
        rd(10'h004, 32'hFD);
        rd(10'h02C, 32'h04);
        rd(10'h300, 32'h01);
        chk({31'h0, irq_o}, 32'h0);
        acc(1'b1, 10'h304, 32'h01);
        chk({31'h0, irq_o}, 32'h1);
        acc(1'b1, 10'h300, 32'h01);
        chk({31'h0, irq_o}, 32'h0);
        // two reads exactly 8 count periods apart (prescaled, then one clock once k is 8 and the watchdog owns it); ratio changes on the fly
        for (int k = 0; k < 9; k++)
        begin
            int dv;
            dv = (k < 8) ? (2 << k) : 1;
            acc(1'b1, 10'h204, 32'(k));
            repeat (2 * dv) @(posedge clk_i);
            acc(1'b0, 10'h004, 32'h0);
            r = q;
            repeat (8 * dv - 3) @(posedge clk_i);
            acc(1'b0, 10'h004, 32'h0);
            chk({24'h0, q[7:0] - r[7:0]}, 32'h8);
        end
        // watchdog already holds the prescaler from the k = 8 pass; counter mode with idle pin, ratio 1:2
        acc(1'b1, 10'h004, 32'h00);
        acc(1'b1, 10'h308, 32'h01);
        acc(1'b1, 10'h204, 32'h28);
        wclr();
        acc(1'b1, 10'h300, 32'h03);
        tick();
        wclr();
        tick();
        rd(10'h300, 32'h00);
        tick();
        rd(10'h300, 32'h02);
        // hand back to the timer: clear the watchdog first
        acc(1'b1, 10'h308, 32'h01);
        // 1:256; a timer write restarts the prescaler, so no tick within 200 cycles
        acc(1'b1, 10'h204, 32'h07);
        acc(1'b1, 10'h004, 32'h00);
        repeat (200) @(posedge clk_i);
        acc(1'b1, 10'h004, 32'h00);
        repeat (200) @(posedge clk_i);
        rd(10'h004, 32'h00);
        watchdog_tick_i <= 1'b1;
        @(posedge clk_i);
        watchdog_tick_i <= 1'b0;
        #1 chk({31'h0, watchdog_tick_o}, 32'h1);
        conclude();
    end
endmodule
`default_nettype wire
